// [core/dps_loss_timer.sv]
// Wait timer that confirms a frequency command loss after a set number of tenths of a second.
module dps_loss_timer #(
  parameter int unsigned TICK_CYCLES = dps_pkg::TICK_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_lost_raw,
  input wire logic [10:0] i_wait_tenths,
  output logic o_lost
);
  dps_pkg::dps_lt_state_t state_q;
  logic [31:0] tick_q;
  logic [10:0] tenth_q;
  logic tick_done;
  assign tick_done = (tick_q == TICK_CYCLES - 1);
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= dps_pkg::LT_IDLE;
    end else if (i_ce) begin
      unique case (state_q)
        dps_pkg::LT_IDLE: begin
          if (i_lost_raw) begin
            state_q <= dps_pkg::LT_WAIT;
          end
        end
        dps_pkg::LT_WAIT: begin
          if (!i_lost_raw) begin
            state_q <= dps_pkg::LT_IDLE;
          end else if (tick_done && tenth_q + 11'h001 >= i_wait_tenths) begin
            state_q <= dps_pkg::LT_LOST;
          end
        end
        dps_pkg::LT_LOST: begin
          if (!i_lost_raw) begin
            state_q <= dps_pkg::LT_IDLE;
          end
        end
        default: state_q <= dps_pkg::LT_IDLE;
      endcase
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_q <= 32'h0;
      tenth_q <= 11'h000;
    end else if (i_ce) begin
      if (state_q != dps_pkg::LT_WAIT || !i_lost_raw) begin
        tick_q <= 32'h0;
        tenth_q <= 11'h000;
      end else if (tick_done) begin
        tick_q <= 32'h0;
        tenth_q <= tenth_q + 11'h001;
      end else begin
        tick_q <= tick_q + 32'h1;
      end
    end
  end
  assign o_lost = (state_q == dps_pkg::LT_LOST);
endmodule

// [core/dps_out_sel.sv]
// Function-code selector for one status output terminal, registered.
module dps_out_sel (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [4:0] i_code,
  input dps_pkg::dps_flags_t i_flags,
  output logic o_pin
);
  logic pin_d;
  always_comb begin
    unique case (i_code)
      dps_pkg::FN_INV_OL: pin_d = i_flags.inv_ol;
      dps_pkg::FN_STALL: pin_d = i_flags.stall;
      dps_pkg::FN_LOSS: pin_d = i_flags.loss;
      dps_pkg::FN_RUN: pin_d = i_flags.run;
      dps_pkg::FN_FAULT: pin_d = i_flags.fault;
      default: pin_d = 1'b0;
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pin <= 1'b0;
    end else if (i_ce) begin
      o_pin <= pin_d;
    end
  end
endmodule

// [core/dps_pkg.sv]
// Shared constants, field layouts and types of the drive protection supervisor.
package dps_pkg;
  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_LEVEL = 6'h04;
  localparam logic [5:0] A_OSEL = 6'h08;
  localparam logic [5:0] A_TLO = 6'h0C;
  localparam logic [5:0] A_THI = 6'h10;
  localparam logic [5:0] A_WAIT = 6'h14;
  localparam logic [5:0] A_AMIN = 6'h18;
  localparam logic [5:0] A_STAT = 6'h1C;
  localparam logic [5:0] A_INVR = 6'h20;
  localparam int CTRL_STALL_LSB = 0;
  localparam int CTRL_PHASE_LSB = 4;
  localparam int CTRL_CRIT_LSB = 8;
  localparam int CTRL_REACT_LSB = 12;
  localparam int CTRL_FRST_BIT = 31;
  localparam int LEVEL_PCT_LSB = 0;
  localparam int LEVEL_RATED_LSB = 16;
  localparam int OSEL_OC_LSB = 0;
  localparam int OSEL_RLY_LSB = 8;
  localparam int TERM_STRIDE = 8;
  localparam int AMIN_V_LSB = 0;
  localparam int AMIN_I_LSB = 16;
  localparam logic [2:0] STALL_SEL_DEF = 3'h0;
  localparam logic [7:0] STALL_PCT_MIN = 8'h1E;
  localparam logic [7:0] STALL_PCT_MAX = 8'hC8;
  localparam logic [7:0] STALL_PCT_DEF = 8'h96;
  localparam logic [1:0] PHASE_SEL_DEF = 2'h0;
  localparam logic [1:0] CRIT_OFF = 2'h0;
  localparam logic [1:0] CRIT_HALF = 2'h1;
  localparam logic [1:0] CRIT_BELOW = 2'h2;
  localparam logic [4:0] TERM_CODE_MAX = 5'h19;
  localparam logic [4:0] TERM_EXT_NO = 5'h12;
  localparam logic [4:0] TERM_EXT_NC = 5'h13;
  localparam logic [4:0] OSEL_MAX = 5'h13;
  localparam logic [4:0] OC_DEF = 5'h0C;
  localparam logic [4:0] RLY_DEF = 5'h11;
  localparam logic [4:0] FN_INV_OL = 5'h06;
  localparam logic [4:0] FN_STALL = 5'h07;
  localparam logic [4:0] FN_LOSS = 5'h0B;
  localparam logic [4:0] FN_RUN = 5'h0C;
  localparam logic [4:0] FN_FAULT = 5'h11;
  localparam logic [2:0] SRC_VPLUSI = 3'h6;
  localparam logic [10:0] WAIT_MIN = 11'h001;
  localparam logic [10:0] WAIT_MAX = 11'h4B0;
  localparam logic [10:0] WAIT_DEF = 11'h00A;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam int unsigned WAIT_UNIT_NS = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_CYC = WAIT_UNIT_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    RE_HOLD = 2'b00,
    RE_COAST = 2'b01,
    RE_DECEL = 2'b10
  } dps_react_t;
  typedef enum logic [1:0] {
    LT_IDLE = 2'b00,
    LT_WAIT = 2'b01,
    LT_LOST = 2'b10
  } dps_lt_state_t;
  typedef struct packed {
    logic fault;
    logic run;
    logic loss;
    logic stall;
    logic inv_ol;
  } dps_flags_t;
endpackage

// [core/dps_supervisor.sv]
// Protection and fault supervisor of a motor drive, with an Avalon-MM register slave.
module dps_supervisor #(
  parameter int unsigned TICK_CYCLES = dps_pkg::TICK_CYC,
  parameter int unsigned CUR_W = 16,
  parameter int unsigned AIN_W = 12
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [CUR_W-1:0] i_out_current,
  input wire logic i_accel,
  input wire logic i_const_speed,
  input wire logic i_decel,
  input wire logic i_dc_link_high,
  input wire logic [2:0] i_out_phase_lost,
  input wire logic [2:0] i_in_phase_lost,
  input wire logic i_cap_replace_due,
  input wire logic [7:0] i_terminal_closed,
  input wire logic [2:0] i_frequency_source_select,
  input wire logic [AIN_W-1:0] i_voltage_analog_input,
  input wire logic [AIN_W-1:0] i_current_analog_input,
  output logic o_out_enable,
  output logic o_fault,
  output logic o_stall_decel,
  output logic o_decel_hold,
  output logic o_hold_freq,
  output logic o_decel_to_stop,
  output logic o_open_collector_output,
  output logic o_changeover_relay_output
);
  localparam int unsigned PW = CUR_W + 8;

  if (CUR_W < 8 || CUR_W > 16 || AIN_W < 2 || AIN_W > 16 || TICK_CYCLES < 1) begin : g_chk
    $error("dps_supervisor: unsupported parameter value");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (nw & m);
  endfunction

  function automatic logic below(input logic [AIN_W-1:0] v, input logic [AIN_W-1:0] mn,
                                 input logic [1:0] crit);
    unique case (crit)
      dps_pkg::CRIT_HALF: below = v < (mn >> 1);
      dps_pkg::CRIT_BELOW: below = v < mn;
      default: below = 1'b0;
    endcase
  endfunction

  logic [2:0] stall_sel_q;
  logic [1:0] phase_sel_q;
  logic [1:0] crit_q;
  dps_pkg::dps_react_t react_q;
  logic [7:0] stall_pct_q;
  logic [CUR_W-1:0] rated_q;
  logic [CUR_W-1:0] inv_rated_q;
  logic [4:0] oc_sel_q;
  logic [4:0] rly_sel_q;
  logic [4:0] term_fn_q [8];
  logic [10:0] wait_q;
  logic [AIN_W-1:0] vmin_q;
  logic [AIN_W-1:0] imin_q;
  logic ack_q;
  logic take_wr;
  logic [31:0] rd_word;
  logic [31:0] wr_word;
  logic fault_rst;
  logic [PW-1:0] cur_scaled;
  logic [PW-1:0] stall_lim;
  logic over_stall_q;
  logic inv_ol_q;
  logic stall_act_q;
  logic [7:0] ext_trip;
  logic [5:0] trip_now;
  logic [5:0] trip_q;
  logic [5:0] trip_d;
  logic lost_raw;
  logic lost;
  dps_pkg::dps_flags_t flags;

  // One wait state on every access keeps the decode and read mux off the bus timing path.
  assign take_wr = i_avs_write && ack_q && i_ce;
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !(ack_q && i_ce);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else if (i_ce) begin
      ack_q <= (i_avs_read || i_avs_write) && !ack_q;
    end
  end

  always_comb begin
    rd_word = 32'h0;
    unique case (i_avs_address)
      dps_pkg::A_CTRL: begin
        rd_word[dps_pkg::CTRL_STALL_LSB +: 3] = stall_sel_q;
        rd_word[dps_pkg::CTRL_PHASE_LSB +: 2] = phase_sel_q;
        rd_word[dps_pkg::CTRL_CRIT_LSB +: 2] = crit_q;
        rd_word[dps_pkg::CTRL_REACT_LSB +: 2] = react_q;
      end
      dps_pkg::A_LEVEL: begin
        rd_word[dps_pkg::LEVEL_PCT_LSB +: 8] = stall_pct_q;
        rd_word[dps_pkg::LEVEL_RATED_LSB +: CUR_W] = rated_q;
      end
      dps_pkg::A_OSEL: begin
        rd_word[dps_pkg::OSEL_OC_LSB +: 5] = oc_sel_q;
        rd_word[dps_pkg::OSEL_RLY_LSB +: 5] = rly_sel_q;
      end
      dps_pkg::A_TLO: begin
        for (int k = 0; k < 4; k++) begin
          rd_word[k*dps_pkg::TERM_STRIDE +: 5] = term_fn_q[k];
        end
      end
      dps_pkg::A_THI: begin
        for (int k = 0; k < 4; k++) begin
          rd_word[k*dps_pkg::TERM_STRIDE +: 5] = term_fn_q[k+4];
        end
      end
      dps_pkg::A_WAIT: rd_word[10:0] = wait_q;
      dps_pkg::A_AMIN: begin
        rd_word[dps_pkg::AMIN_V_LSB +: AIN_W] = vmin_q;
        rd_word[dps_pkg::AMIN_I_LSB +: AIN_W] = imin_q;
      end
      dps_pkg::A_STAT: rd_word = {21'h0, trip_q, flags};
      dps_pkg::A_INVR: rd_word[CUR_W-1:0] = inv_rated_q;
      default: rd_word = 32'h0;
    endcase
  end

  assign wr_word = merge(rd_word, i_avs_writedata, i_avs_byteenable);
  assign fault_rst = take_wr && i_avs_address == dps_pkg::A_CTRL && i_avs_byteenable[3]
                     && i_avs_writedata[dps_pkg::CTRL_FRST_BIT];

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h0;
    end else if (i_ce && i_avs_read && !ack_q) begin
      // Loaded in the wait state, so the word already stands at the edge that completes the read.
      o_avs_readdata <= rd_word;
    end
  end

  // Out-of-range values are dropped field by field so the setting never leaves its legal span.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stall_sel_q <= dps_pkg::STALL_SEL_DEF;
      phase_sel_q <= dps_pkg::PHASE_SEL_DEF;
      crit_q <= dps_pkg::CRIT_OFF;
      react_q <= dps_pkg::RE_HOLD;
    end else if (i_ce && take_wr && i_avs_address == dps_pkg::A_CTRL) begin
      stall_sel_q <= wr_word[dps_pkg::CTRL_STALL_LSB +: 3];
      phase_sel_q <= wr_word[dps_pkg::CTRL_PHASE_LSB +: 2];
      if (wr_word[dps_pkg::CTRL_CRIT_LSB +: 2] <= dps_pkg::CRIT_BELOW) begin
        crit_q <= wr_word[dps_pkg::CTRL_CRIT_LSB +: 2];
      end
      if (wr_word[dps_pkg::CTRL_REACT_LSB +: 2] <= dps_pkg::RE_DECEL) begin
        react_q <= dps_pkg::dps_react_t'(wr_word[dps_pkg::CTRL_REACT_LSB +: 2]);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stall_pct_q <= dps_pkg::STALL_PCT_DEF;
      rated_q <= '1;
      inv_rated_q <= '1;
    end else if (i_ce && take_wr) begin
      if (i_avs_address == dps_pkg::A_LEVEL) begin
        if (wr_word[dps_pkg::LEVEL_PCT_LSB +: 8] >= dps_pkg::STALL_PCT_MIN
            && wr_word[dps_pkg::LEVEL_PCT_LSB +: 8] <= dps_pkg::STALL_PCT_MAX) begin
          stall_pct_q <= wr_word[dps_pkg::LEVEL_PCT_LSB +: 8];
        end
        rated_q <= wr_word[dps_pkg::LEVEL_RATED_LSB +: CUR_W];
      end
      if (i_avs_address == dps_pkg::A_INVR) begin
        inv_rated_q <= wr_word[CUR_W-1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oc_sel_q <= dps_pkg::OC_DEF;
      rly_sel_q <= dps_pkg::RLY_DEF;
    end else if (i_ce && take_wr && i_avs_address == dps_pkg::A_OSEL) begin
      if (wr_word[dps_pkg::OSEL_OC_LSB +: 5] <= dps_pkg::OSEL_MAX) begin
        oc_sel_q <= wr_word[dps_pkg::OSEL_OC_LSB +: 5];
      end
      if (wr_word[dps_pkg::OSEL_RLY_LSB +: 5] <= dps_pkg::OSEL_MAX) begin
        rly_sel_q <= wr_word[dps_pkg::OSEL_RLY_LSB +: 5];
      end
    end
  end

  for (genvar t = 0; t < 8; t++) begin : g_term
    localparam logic [5:0] TADDR = (t < 4) ? dps_pkg::A_TLO : dps_pkg::A_THI;
    localparam int TLSB = (t % 4) * dps_pkg::TERM_STRIDE;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        term_fn_q[t] <= 5'(t);
      end else if (i_ce && take_wr && i_avs_address == TADDR
                   && wr_word[TLSB +: 5] <= dps_pkg::TERM_CODE_MAX) begin
        term_fn_q[t] <= wr_word[TLSB +: 5];
      end
    end
    // A normally-closed contact trips on an open circuit, so a broken wire also stops the drive.
    assign ext_trip[t] = (term_fn_q[t] == dps_pkg::TERM_EXT_NO && i_terminal_closed[t])
                         || (term_fn_q[t] == dps_pkg::TERM_EXT_NC && !i_terminal_closed[t]);
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_q <= dps_pkg::WAIT_DEF;
      vmin_q <= '0;
      imin_q <= '0;
    end else if (i_ce && take_wr) begin
      if (i_avs_address == dps_pkg::A_WAIT && wr_word[10:0] >= dps_pkg::WAIT_MIN
          && wr_word[10:0] <= dps_pkg::WAIT_MAX && wr_word[31:11] == 21'h0) begin
        wait_q <= wr_word[10:0];
      end
      if (i_avs_address == dps_pkg::A_AMIN) begin
        vmin_q <= wr_word[dps_pkg::AMIN_V_LSB +: AIN_W];
        imin_q <= wr_word[dps_pkg::AMIN_I_LSB +: AIN_W];
      end
    end
  end

  assign cur_scaled = PW'(i_out_current) * PW'(dps_pkg::PCT_FULL);
  assign stall_lim = PW'(rated_q) * PW'(stall_pct_q);

  // Both comparisons run every cycle; their results drive status one edge later.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      over_stall_q <= 1'b0;
      inv_ol_q <= 1'b0;
    end else if (i_ce) begin
      over_stall_q <= cur_scaled > stall_lim;
      inv_ol_q <= i_out_current > inv_rated_q;
    end
  end

  // Ramp outputs are requests to the ramp generator, which stretches the ramp while they stand.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_stall_decel <= 1'b0;
      o_decel_hold <= 1'b0;
      stall_act_q <= 1'b0;
    end else if (i_ce) begin
      o_stall_decel <= over_stall_q && ((stall_sel_q[0] && i_accel)
                                        || (stall_sel_q[1] && i_const_speed));
      o_decel_hold <= stall_sel_q[2] && i_decel && i_dc_link_high;
      stall_act_q <= over_stall_q || (i_decel && i_dc_link_high);
    end
  end

  assign lost_raw = below(i_voltage_analog_input, vmin_q, crit_q)
                    || (i_frequency_source_select == dps_pkg::SRC_VPLUSI
                        && below(i_current_analog_input, imin_q, crit_q));

  dps_loss_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_loss (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_lost_raw(lost_raw),
    .i_wait_tenths(wait_q),
    .o_lost(lost)
  );

  assign trip_now[0] = |ext_trip;
  assign trip_now[1] = phase_sel_q[0] && |i_out_phase_lost;
  assign trip_now[2] = phase_sel_q[1] && |i_in_phase_lost;
  assign trip_now[3] = phase_sel_q[1] && !(|i_in_phase_lost) && i_cap_replace_due;
  assign trip_now[4] = lost && react_q == dps_pkg::RE_COAST;
  assign trip_now[5] = 1'b0;

  // A cause still present at the reset write survives it, so no trip is lost.
  assign trip_d = (fault_rst ? 6'h00 : trip_q) | trip_now;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trip_q <= 6'h00;
    end else if (i_ce) begin
      trip_q <= trip_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_enable <= 1'b0;
      o_fault <= 1'b0;
      o_hold_freq <= 1'b0;
      o_decel_to_stop <= 1'b0;
    end else if (i_ce) begin
      o_out_enable <= !(|trip_d);
      o_fault <= |trip_d;
      o_hold_freq <= lost && react_q == dps_pkg::RE_HOLD;
      o_decel_to_stop <= lost && react_q == dps_pkg::RE_DECEL;
    end
  end

  assign flags.fault = o_fault;
  assign flags.run = o_out_enable;
  assign flags.loss = lost;
  assign flags.stall = stall_act_q;
  assign flags.inv_ol = inv_ol_q;

  dps_out_sel u_oc (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_code(oc_sel_q),
    .i_flags(flags),
    .o_pin(o_open_collector_output)
  );

  dps_out_sel u_rly (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_code(rly_sel_q),
    .i_flags(flags),
    .o_pin(o_changeover_relay_output)
  );
endmodule

// [verification/dps_ext_seq.sv]
// External control sequence model: a contact bank wired to the input terminals.
module dps_ext_seq (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_contacts,
  output logic [7:0] o_terminal_closed
);
  // Contacts move on the clock, so the supervisor never sees a change mid-cycle.
  always_ff @(posedge i_sys_clk) begin
    o_terminal_closed <= i_contacts;
  end
endmodule

// [verification/dps_supervisor_props.sv]
// Port-level assertions of the drive protection supervisor.
module dps_supervisor_props #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire logic i_accel,
  input wire logic i_const_speed,
  input wire logic i_decel,
  input wire logic i_dc_link_high,
  input wire logic o_out_enable,
  input wire logic o_fault,
  input wire logic o_stall_decel,
  input wire logic o_decel_hold,
  input wire logic o_hold_freq,
  input wire logic o_decel_to_stop
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic frst;
  // Only a completed write that carries lane 3 may clear a latched fault.
  assign frst = i_avs_write && !o_avs_waitrequest && i_avs_address == dps_pkg::A_CTRL
    && i_avs_byteenable[3] && i_avs_writedata[31];
  sequence s_wait;
    (i_avs_read || i_avs_write) && o_avs_waitrequest && i_ce;
  endsequence
  sequence s_done;
    (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  endsequence
  a_wait_first: assert property ($rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest)
    else $error("request answered with no wait state");
  a_wait_once: assert property (s_wait |=> s_done)
    else $error("request waited more than one cycle");
  a_read_stands: assert property (!i_avs_read |=> $stable(o_avs_readdata))
    else $error("read data changed without a read");
  a_fault_off: assert property (o_fault |-> !o_out_enable)
    else $error("output enabled while fault shown");
  a_fault_latch: assert property (o_fault && !frst |=> o_fault)
    else $error("fault cleared without fault reset");
  a_trip_flags: assert property ($fell(o_out_enable) |-> o_fault)
    else $error("output cut without fault");
  a_stall_cause: assert property (o_stall_decel |-> $past(i_accel) || $past(i_const_speed))
    else $error("stall decel outside accel or constant speed");
  a_hold_cause: assert property (o_decel_hold |-> $past(i_decel) && $past(i_dc_link_high))
    else $error("decel hold without decel and high link");
  a_react_excl: assert property (!(o_hold_freq && o_decel_to_stop))
    else $error("two loss reactions at once");
endmodule

bind dps_supervisor dps_supervisor_props #(.TICK_CYCLES(TICK_CYCLES)) dps_supervisor_props_inst (.*);

// [verification/dps_supervisor_tb.sv]
// Self-checking testbench of the drive protection supervisor.
module dps_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, ce, rd, wr, accel, cnst, decel, dch, cap, wreq, oe, flt, sd, dh, hf, dts, oc, rly;
  logic [5:0] addr;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  logic [15:0] cur;
  logic [2:0] opl, ipl, src;
  logic [7:0] contacts, term;
  logic [11:0] vin, iin;
  int mismatches, n_tests;
  dps_supervisor #(.TICK_CYCLES(4)) dps_supervisor_inst (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(ce),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_out_current(cur),
    .i_accel(accel), .i_const_speed(cnst), .i_decel(decel), .i_dc_link_high(dch), .i_out_phase_lost(opl),
    .i_in_phase_lost(ipl), .i_cap_replace_due(cap), .i_terminal_closed(term), .i_frequency_source_select(src),
    .i_voltage_analog_input(vin), .i_current_analog_input(iin), .o_out_enable(oe), .o_fault(flt),
    .o_stall_decel(sd), .o_decel_hold(dh), .o_hold_freq(hf), .o_decel_to_stop(dts),
    .o_open_collector_output(oc), .o_changeover_relay_output(rly));
  dps_ext_seq dps_ext_seq_inst (.i_sys_clk(clk), .i_contacts(contacts), .o_terminal_closed(term));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // The request is held until the edge that samples waitrequest low.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wr32(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask
  task automatic t_regs();
    rd_chk("ctrl", dps_pkg::A_CTRL, 32'h0);
    rd_chk("level", dps_pkg::A_LEVEL, 32'hFFFF0096);
    rd_chk("osel", dps_pkg::A_OSEL, 32'h0000110C);
    rd_chk("wait", dps_pkg::A_WAIT, 32'h0000000A);
    rd_chk("terms", dps_pkg::A_TLO, 32'h03020100);
    rd_chk("unmapped", 6'h24, 32'h0);
    wr32(dps_pkg::A_LEVEL, 32'hFFFF001D);
    rd_chk("pct_low", dps_pkg::A_LEVEL, 32'hFFFF0096);
    wr32(dps_pkg::A_LEVEL, 32'hFFFF00C9);
    rd_chk("pct_high", dps_pkg::A_LEVEL, 32'hFFFF0096);
    wr32(dps_pkg::A_OSEL, 32'h00001114);
    rd_chk("osel_bad", dps_pkg::A_OSEL, 32'h0000110C);
    wr32(dps_pkg::A_CTRL, 32'h00003000);
    rd_chk("react_bad", dps_pkg::A_CTRL, 32'h0);
    wr32(dps_pkg::A_TLO, 32'h1A020100);
    rd_chk("term_bad", dps_pkg::A_TLO, 32'h03020100);
    $display("t_regs done");
  endtask
  task automatic t_stall();
    wr32(dps_pkg::A_INVR, 32'h000000C8);
    wr32(dps_pkg::A_LEVEL, 32'h00640064);
    wr32(dps_pkg::A_OSEL, 32'h00000607);
    wr32(dps_pkg::A_CTRL, 32'h1);
    accel <= 1'b1;
    cur <= 16'h0065;
    cyc(5);
    check("stall_acc", sd, 1'b1);
    check("oc_stall", oc, 1'b1);
    ce <= 1'b0;
    cur <= 16'h0064;
    cyc(5);
    check("ce_freeze", sd, 1'b1);
    ce <= 1'b1;
    cyc(5);
    check("stall_edge", sd, 1'b0);
    accel <= 1'b0;
    cnst <= 1'b1;
    cur <= 16'h0065;
    cyc(5);
    check("stall_masked", sd, 1'b0);
    check("oc_masked", oc, 1'b1);
    wr32(dps_pkg::A_CTRL, 32'h2);
    cyc(5);
    check("stall_const", sd, 1'b1);
    cur <= 16'h00C9;
    cyc(5);
    check("inv_ol", rly, 1'b1);
    cur <= 16'h0000;
    cnst <= 1'b0;
    decel <= 1'b1;
    dch <= 1'b1;
    wr32(dps_pkg::A_CTRL, 32'h4);
    cyc(5);
    check("decel_hold", dh, 1'b1);
    check("oc_dc", oc, 1'b1);
    wr32(dps_pkg::A_CTRL, 32'h0);
    cyc(5);
    check("hold_off", dh, 1'b0);
    decel <= 1'b0;
    dch <= 1'b0;
    $display("t_stall done");
  endtask
  task automatic t_trip();
    wr32(dps_pkg::A_THI, 32'h13120504);
    for (int i = 0; i < 6; i++) begin
      wr32(dps_pkg::A_CTRL, i < 3 ? 32'h0 : (i == 3 ? 32'h10 : 32'h20));
      contacts <= i == 0 ? 8'hC0 : (i == 1 ? 8'h00 : 8'h80);
      opl <= (i == 2 || i == 3) ? 3'h2 : 3'h0;
      ipl <= i == 4 ? 3'h4 : 3'h0;
      cap <= i == 5;
      cyc(4);
      check("out_enable", oe, i == 2);
      contacts <= 8'h80;
      opl <= 3'h0;
      ipl <= 3'h0;
      cap <= 1'b0;
      cyc(4);
      check("fault_latched", flt, i != 2);
      wr32(dps_pkg::A_CTRL, 32'h80000000);
      cyc(3);
      check("recovered", oe, 1'b1);
    end
    $display("t_trip done");
  endtask
  task automatic t_loss();
    wr32(dps_pkg::A_AMIN, 32'h00000100);
    wr32(dps_pkg::A_WAIT, 32'h1);
    wr32(dps_pkg::A_OSEL, 32'h0000110B);
    for (int r = 0; r < 3; r++) begin
      wr32(dps_pkg::A_CTRL, {18'h0, 2'(r), 12'h200});
      vin <= 12'h0FF;
      cyc(3);
      check("early", {hf, dts}, 2'h0);
      cyc(12);
      check("hold", hf, r == 0);
      check("decel_stop", dts, r == 2);
      check("coast", oe, r != 1);
      check("loss_pin", oc, 1'b1);
      vin <= 12'h200;
      wr32(dps_pkg::A_CTRL, 32'h80000000);
      cyc(4);
    end
    wr32(dps_pkg::A_CTRL, 32'h100);
    vin <= 12'h0FF;
    cyc(15);
    check("half_ok", hf, 1'b0);
    vin <= 12'h07F;
    cyc(15);
    check("half_lost", hf, 1'b1);
    vin <= 12'h200;
    src <= 3'h6;
    wr32(dps_pkg::A_AMIN, 32'h01000100);
    wr32(dps_pkg::A_CTRL, 32'h200);
    iin <= 12'h0FF;
    cyc(15);
    check("vplusi", hf, 1'b1);
    $display("t_loss done");
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    mismatches = 0;
    n_tests = 0;
    {rst_n, rd, wr, accel, cnst, decel, dch, cap} = 8'h00;
    ce = 1'b1;
    addr = 6'h00;
    wdata = 32'h0;
    be = 4'hF;
    cur = 16'h0000;
    {opl, ipl} = 6'h00;
    src = 3'h3;
    contacts = 8'h80;
    vin = 12'h200;
    iin = 12'hFFF;
    cyc(2);
    rst_n <= 1'b1;
    t_regs();
    t_stall();
    t_trip();
    t_loss();
    conclude();
  end
  // The run needs well under two thousand cycles.
  initial begin
    cyc(20000);
    mismatches++;
    conclude();
  end
endmodule
